//--- logic/lowpower_pkg.sv
package lowpower_pkg;

    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [15:0] ADDR_BASIC_CTRL = 16'h0000;
    localparam logic [15:0] ADDR_CTRL_STATUS_TWO = 16'h0015;
    localparam logic [15:0] ADDR_IND_ONE = 16'h001b;
    localparam logic [15:0] ADDR_IND_TWO = 16'h001c;
    localparam logic [15:0] ADDR_IND_THREE = 16'h001d;
    localparam logic [15:0] ADDR_LPI_ADV = 16'h8001;
    localparam logic [15:0] ADDR_GCLK_CTRL = 16'hff1f;

    // ----------------------------------------
    // field positions and reset values
    // ----------------------------------------
    localparam int SOFT_PD_BIT = 11;
    localparam int SLEEP_EN_BIT = 3;
    localparam int SLEEP_STATE_BIT = 4;
    localparam int LPI_FAST_ADV_BIT = 1;
    localparam int IND_DEFAULT_BIT = 0;
    localparam logic [15:0] IND_ONE_RESET = 16'h0001;
    localparam logic [15:0] IND_TWO_RESET = 16'h0000;
    localparam logic [15:0] IND_THREE_RESET = 16'h0000;

    // ----------------------------------------
    // strap modes and clock selection
    // ----------------------------------------
    localparam logic [1:0] MODE_1 = 2'h0;
    localparam logic [1:0] MODE_2 = 2'h1;
    localparam logic [1:0] MODE_3 = 2'h2;
    localparam logic [1:0] MODE_4 = 2'h3;
    localparam logic [1:0] GCLK_OFF = 2'h0;
    localparam logic [1:0] GCLK_FREE_FAST = 2'h1;
    localparam logic [1:0] GCLK_REF_SLOW = 2'h2;
    localparam logic [1:0] GCLK_RECOVERED = 2'h3;
    localparam logic [1:0] IND_FN_OFF = 2'h0;
    localparam logic [1:0] IND_FN_ON = 2'h1;
    localparam logic [1:0] IND_FN_LINK = 2'h2;
    localparam logic [1:0] IND_FN_ACTIVITY = 2'h3;
    localparam logic [1:0] STRAP_SETTLE = 2'h3;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_HZ = 250_000_000;
    localparam int SILENCE_S = 3;
    localparam int PULSE_PERIOD_S = 1;
    localparam int WAKE_US = 20;
    localparam int REFRESH_US = 20_000;
    localparam int BLINK_MS = 50;
    localparam int SILENCE_CYCLES = SILENCE_S * CLK_HZ;
    localparam int PULSE_CYCLES = PULSE_PERIOD_S * CLK_HZ;
    localparam int WAKE_CYCLES = WAKE_US * (CLK_HZ / 1_000_000);
    localparam int REFRESH_CYCLES = REFRESH_US * (CLK_HZ / 1_000_000);
    localparam int BLINK_CYCLES = BLINK_MS * (CLK_HZ / 1_000);

    typedef enum logic [2:0] {
        PWR_STRAP = 3'h0,
        PWR_SOFT_PD = 3'h1,
        PWR_NORMAL = 3'h2,
        PWR_SLEEP = 3'h3,
        PWR_LPI = 3'h4,
        PWR_WAKE = 3'h5
    } pwr_state_t;

    typedef struct packed {
        logic sleep_en;
        logic lpi_adv;
        logic soft_pd;
        logic ind_active_low;
        logic two_level;
    } strap_cfg_t;

endpackage

//--- logic/interval_timer.sv
`timescale 1ns/1ps
`default_nettype none
module interval_timer
    import lowpower_pkg::*;
#(
    parameter int PERIOD = 16
)(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // control
    input wire logic run,
    output logic tick
);

    logic [31:0] count_reg;
    logic [31:0] count_next;
    logic tick_reg;
    logic tick_next;

    // count restarts whenever run drops, so each run measures a whole period
    always_comb
    begin
        count_next = 32'h0;
        tick_next = 1'b0;
        if (run)
        begin
            if (count_reg >= 32'(PERIOD - 1))
            begin
                tick_next = 1'b1;
            end
            else
            begin
                count_next = count_reg + 32'h1;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            count_reg <= 32'h0;
            tick_reg <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            tick_reg <= tick_next;
        end
    end

    assign tick = tick_reg;

endmodule
`default_nettype wire

//--- logic/strap_level_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module strap_level_decoder
    import lowpower_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // comparators above 0.1, 0.5, 0.9 of supply
    input wire logic [2:0] above_level,
    // decode
    output logic [1:0] mode,
    output logic two_level_valid,
    output logic two_level_high
);

    logic [2:0] meta_reg;
    logic [2:0] sync_reg;

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            meta_reg <= 3'h0;
            sync_reg <= 3'h0;
        end
        else
        begin
            meta_reg <= above_level;
            sync_reg <= meta_reg;
        end
    end

    // highest threshold crossed wins
    always_comb
    begin
        if (sync_reg[2])
            mode = MODE_4;
        else if (sync_reg[1])
            mode = MODE_3;
        else if (sync_reg[0])
            mode = MODE_2;
        else
            mode = MODE_1;
    end

    // middle levels are not a valid two-level setting
    assign two_level_valid = (mode == MODE_1) || (mode == MODE_4);
    assign two_level_high = (mode == MODE_4);

endmodule
`default_nettype wire

//--- logic/lowpower_control.sv
`timescale 1ns/1ps
`default_nettype none
module lowpower_control
    import lowpower_pkg::*;
#(
    parameter int SILENCE = SILENCE_CYCLES,
    parameter int PULSE_PERIOD = PULSE_CYCLES,
    parameter int WAKE = WAKE_CYCLES,
    parameter int REFRESH = REFRESH_CYCLES,
    parameter int BLINK = BLINK_CYCLES
)(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // management register port
    input wire logic [15:0] mgmt_addr,
    input wire logic mgmt_wr,
    input wire logic mgmt_rd,
    input wire logic [15:0] mgmt_wdata,
    output logic [15:0] mgmt_rdata,
    output logic mgmt_ack,
    // strap comparators
    input wire logic [2:0] strap_config_high,
    input wire logic [2:0] strap_config_low,
    input wire logic [2:0] strap_two_level_pin,
    // line and link status
    input wire logic line_energy,
    input wire logic link_up,
    input wire logic link_fast,
    input wire logic partner_lpi_fast,
    input wire logic activity,
    // MAC side
    input wire logic mac_lpi_request,
    input wire logic mac_tx_busy,
    input wire logic remote_wake,
    output logic tx_ready,
    output logic lpi_link,
    output logic lpi_active,
    // line drive
    output logic link_pulse,
    output logic link_pulse_continuous,
    output logic refresh_tx,
    // clocks and power
    output logic clocks_gated,
    output logic cmu_power,
    output logic [1:0] general_clock_sel,
    // status indicator pin
    output logic status_indicator_out,
    output logic status_indicator_oe_n,
    output logic strap_two_level_value
);

    // ----------------------------------------
    // strap sensing
    // ----------------------------------------
    logic [1:0] mode_high;
    logic [1:0] mode_low;
    logic two_valid;
    logic two_high;
    logic [1:0] settle_reg;
    logic [1:0] settle_next;
    logic strap_done_reg;
    logic strap_done_next;
    strap_cfg_t strap_reg;
    strap_cfg_t strap_next;
    strap_cfg_t strap_now;

    strap_level_decoder u_cfg_high (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .above_level(strap_config_high),
        .mode(mode_high),
        .two_level_valid(),
        .two_level_high()
    );

    strap_level_decoder u_cfg_low (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .above_level(strap_config_low),
        .mode(mode_low),
        .two_level_valid(),
        .two_level_high()
    );

    strap_level_decoder u_cfg_two (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .above_level(strap_two_level_pin),
        .mode(),
        .two_level_valid(two_valid),
        .two_level_high(two_high)
    );

    always_comb
    begin
        strap_now.sleep_en = (mode_high == MODE_4) && (mode_low == MODE_4);
        strap_now.lpi_adv = (mode_high == MODE_4) && (mode_low == MODE_4);
        strap_now.soft_pd = (mode_high == MODE_3) && (mode_low == MODE_4);
        // a pin pulled toward the supply reads high at reset
        strap_now.ind_active_low = (mode_low == MODE_4) || (mode_low == MODE_3);
        strap_now.two_level = two_valid && two_high;
        settle_next = settle_reg;
        strap_done_next = strap_done_reg;
        strap_next = strap_reg;
        // wait for the synchronisers to fill before latching
        if (!strap_done_reg)
        begin
            if (settle_reg == STRAP_SETTLE)
            begin
                strap_done_next = 1'b1;
                strap_next = strap_now;
            end
            else
            begin
                settle_next = settle_reg + 2'h1;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            settle_reg <= 2'h0;
            strap_done_reg <= 1'b0;
            strap_reg <= '0;
        end
        else
        begin
            settle_reg <= settle_next;
            strap_done_reg <= strap_done_next;
            strap_reg <= strap_next;
        end
    end

    // ----------------------------------------
    // line synchroniser and timers
    // ----------------------------------------
    logic energy_meta_reg;
    logic energy_reg;
    pwr_state_t state_reg;
    pwr_state_t state_next;
    logic sleep_en_reg;
    logic silence_tick;
    logic second_tick;
    logic wake_tick;
    logic refresh_tick;
    logic blink_tick;

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            energy_meta_reg <= 1'b0;
            energy_reg <= 1'b0;
        end
        else
        begin
            energy_meta_reg <= line_energy;
            energy_reg <= energy_meta_reg;
        end
    end

    interval_timer #(.PERIOD(SILENCE)) u_silence (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .run((state_reg == PWR_NORMAL) && sleep_en_reg && !energy_reg),
        .tick(silence_tick)
    );

    interval_timer #(.PERIOD(PULSE_PERIOD)) u_second (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .run(state_reg == PWR_SLEEP),
        .tick(second_tick)
    );

    interval_timer #(.PERIOD(WAKE)) u_wake (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .run(state_reg == PWR_WAKE),
        .tick(wake_tick)
    );

    interval_timer #(.PERIOD(REFRESH)) u_refresh (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .run(state_reg == PWR_LPI),
        .tick(refresh_tick)
    );

    interval_timer #(.PERIOD(BLINK)) u_blink (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .run(1'b1),
        .tick(blink_tick)
    );

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic soft_pd_reg;
    logic soft_pd_next;
    logic sleep_en_next;
    logic lpi_adv_reg;
    logic lpi_adv_next;
    logic [15:0] ind_one_reg;
    logic [15:0] ind_one_next;
    logic [15:0] ind_two_reg;
    logic [15:0] ind_two_next;
    logic [15:0] ind_three_reg;
    logic [15:0] ind_three_next;
    logic [1:0] gclk_reg;
    logic [1:0] gclk_next;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic ack_reg;
    logic ack_next;
    logic lpi_ok;

    always_comb
    begin
        soft_pd_next = soft_pd_reg;
        sleep_en_next = sleep_en_reg;
        lpi_adv_next = lpi_adv_reg;
        ind_one_next = ind_one_reg;
        ind_two_next = ind_two_reg;
        ind_three_next = ind_three_reg;
        gclk_next = gclk_reg;
        rdata_next = rdata_reg;
        ack_next = mgmt_wr || mgmt_rd;
        // pin dependent defaults land when the straps are latched
        if (!strap_done_reg && strap_done_next)
        begin
            soft_pd_next = strap_now.soft_pd;
            sleep_en_next = strap_now.sleep_en;
            lpi_adv_next = strap_now.lpi_adv;
        end
        else if (mgmt_wr)
        begin
            unique case (mgmt_addr)
                ADDR_BASIC_CTRL: soft_pd_next = mgmt_wdata[SOFT_PD_BIT];
                ADDR_CTRL_STATUS_TWO: sleep_en_next = mgmt_wdata[SLEEP_EN_BIT];
                ADDR_LPI_ADV: lpi_adv_next = mgmt_wdata[LPI_FAST_ADV_BIT];
                ADDR_IND_ONE: ind_one_next = mgmt_wdata;
                ADDR_IND_TWO: ind_two_next = mgmt_wdata;
                ADDR_IND_THREE: ind_three_next = mgmt_wdata;
                ADDR_GCLK_CTRL: gclk_next = mgmt_wdata[1:0];
                default: ;
            endcase
        end
        // registers stay readable in every power state
        if (mgmt_rd)
        begin
            rdata_next = 16'h0000;
            unique case (mgmt_addr)
                ADDR_BASIC_CTRL: rdata_next[SOFT_PD_BIT] = soft_pd_reg;
                ADDR_CTRL_STATUS_TWO:
                begin
                    rdata_next[SLEEP_EN_BIT] = sleep_en_reg;
                    rdata_next[SLEEP_STATE_BIT] = (state_reg == PWR_SLEEP);
                end
                ADDR_LPI_ADV: rdata_next[LPI_FAST_ADV_BIT] = lpi_adv_reg;
                ADDR_IND_ONE: rdata_next = ind_one_reg;
                ADDR_IND_TWO: rdata_next = ind_two_reg;
                ADDR_IND_THREE: rdata_next = ind_three_reg;
                ADDR_GCLK_CTRL: rdata_next[1:0] = gclk_reg;
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            soft_pd_reg <= 1'b0;
            sleep_en_reg <= 1'b0;
            lpi_adv_reg <= 1'b0;
            ind_one_reg <= IND_ONE_RESET;
            ind_two_reg <= IND_TWO_RESET;
            ind_three_reg <= IND_THREE_RESET;
            gclk_reg <= GCLK_OFF;
            rdata_reg <= 16'h0000;
            ack_reg <= 1'b0;
        end
        else
        begin
            soft_pd_reg <= soft_pd_next;
            sleep_en_reg <= sleep_en_next;
            lpi_adv_reg <= lpi_adv_next;
            ind_one_reg <= ind_one_next;
            ind_two_reg <= ind_two_next;
            ind_three_reg <= ind_three_next;
            gclk_reg <= gclk_next;
            rdata_reg <= rdata_next;
            ack_reg <= ack_next;
        end
    end

    // ----------------------------------------
    // power state machine
    // ----------------------------------------
    // advertised by both ends and running at the advertised speed
    assign lpi_ok = lpi_adv_reg && partner_lpi_fast && link_up && link_fast;

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            PWR_STRAP:
            begin
                if (strap_done_next)
                    state_next = strap_now.soft_pd ? PWR_SOFT_PD : PWR_NORMAL;
            end
            PWR_SOFT_PD:
            begin
                if (!soft_pd_reg)
                    state_next = PWR_NORMAL;
            end
            PWR_NORMAL:
            begin
                if (silence_tick)
                    state_next = PWR_SLEEP;
                // only between frames, on the MAC's request
                else if (lpi_ok && mac_lpi_request && !mac_tx_busy)
                    state_next = PWR_LPI;
            end
            PWR_SLEEP:
            begin
                if (energy_reg)
                    state_next = PWR_NORMAL;
            end
            PWR_LPI:
            begin
                if (!link_up)
                    state_next = PWR_NORMAL;
                else if (!mac_lpi_request || remote_wake)
                    state_next = PWR_WAKE;
            end
            PWR_WAKE:
            begin
                if (wake_tick)
                    state_next = PWR_NORMAL;
            end
            default: state_next = PWR_NORMAL;
        endcase
        if (state_reg != PWR_STRAP && soft_pd_reg)
            state_next = PWR_SOFT_PD;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
            state_reg <= PWR_STRAP;
        else
            state_reg <= state_next;
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    logic pulse_reg;
    logic pulse_next;
    logic cont_reg;
    logic cont_next;
    logic refresh_reg;
    logic refresh_next;
    logic gated_reg;
    logic gated_next;
    logic cmu_reg;
    logic cmu_next;
    logic [1:0] gclk_out_reg;
    logic [1:0] gclk_out_next;
    logic ready_reg;
    logic ready_next;
    logic lpi_link_reg;
    logic lpi_active_reg;
    logic blink_reg;
    logic blink_next;
    logic lit;
    logic ind_reg;
    logic ind_next;
    logic oe_n_reg;
    logic oe_n_next;

    always_comb
    begin
        pulse_next = second_tick && (state_reg == PWR_SLEEP);
        cont_next = (state_reg == PWR_NORMAL) && !link_up;
        refresh_next = refresh_tick && (state_reg == PWR_LPI);
        gated_next = (state_reg == PWR_SLEEP) || (state_reg == PWR_LPI)
            || (state_reg == PWR_SOFT_PD);
        cmu_next = (state_reg != PWR_STRAP) && ((gclk_reg == GCLK_FREE_FAST)
            || (state_reg == PWR_NORMAL) || (state_reg == PWR_WAKE));
        // output clock selection does not depend on the power state
        gclk_out_next = strap_done_reg ? gclk_reg : GCLK_OFF;
        // data path held off until the wake time has run out
        ready_next = (state_reg == PWR_NORMAL) && link_up;
        blink_next = blink_tick ? !blink_reg : blink_reg;
        lit = 1'b0;
        if (ind_one_reg[IND_DEFAULT_BIT])
        begin
            lit = link_up && !(activity && blink_reg);
        end
        else
        begin
            unique case (ind_two_reg[1:0])
                IND_FN_OFF: lit = 1'b0;
                IND_FN_ON: lit = 1'b1;
                IND_FN_LINK: lit = link_up;
                IND_FN_ACTIVITY: lit = activity && blink_reg;
            endcase
            lit = lit ^ ind_three_reg[0];
        end
        ind_next = lit ^ strap_reg.ind_active_low;
        // pin left undriven until the straps have been read
        oe_n_next = !strap_done_reg;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            pulse_reg <= 1'b0;
            cont_reg <= 1'b0;
            refresh_reg <= 1'b0;
            gated_reg <= 1'b0;
            cmu_reg <= 1'b0;
            gclk_out_reg <= GCLK_OFF;
            ready_reg <= 1'b0;
            lpi_link_reg <= 1'b0;
            lpi_active_reg <= 1'b0;
            blink_reg <= 1'b0;
            ind_reg <= 1'b0;
            oe_n_reg <= 1'b1;
        end
        else
        begin
            pulse_reg <= pulse_next;
            cont_reg <= cont_next;
            refresh_reg <= refresh_next;
            gated_reg <= gated_next;
            cmu_reg <= cmu_next;
            gclk_out_reg <= gclk_out_next;
            ready_reg <= ready_next;
            lpi_link_reg <= lpi_ok;
            lpi_active_reg <= (state_reg == PWR_LPI);
            blink_reg <= blink_next;
            ind_reg <= ind_next;
            oe_n_reg <= oe_n_next;
        end
    end

    assign mgmt_rdata = rdata_reg;
    assign mgmt_ack = ack_reg;
    assign tx_ready = ready_reg;
    assign lpi_link = lpi_link_reg;
    assign lpi_active = lpi_active_reg;
    assign link_pulse = pulse_reg;
    assign link_pulse_continuous = cont_reg;
    assign refresh_tx = refresh_reg;
    assign clocks_gated = gated_reg;
    assign cmu_power = cmu_reg;
    assign general_clock_sel = gclk_out_reg;
    assign status_indicator_out = ind_reg;
    assign status_indicator_oe_n = oe_n_reg;
    assign strap_two_level_value = strap_reg.two_level;

endmodule
`default_nettype wire

//--- verification/lowpower_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module lowpower_asserts
    import lowpower_pkg::*;
#(
    parameter int WAKE = 10
)(
    // watched ports
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic mgmt_rd,
    input wire logic mgmt_ack,
    input wire logic link_up,
    input wire logic mac_tx_busy,
    input wire logic tx_ready,
    input wire logic lpi_link,
    input wire logic lpi_active,
    input wire logic link_pulse,
    input wire logic link_pulse_continuous,
    input wire logic refresh_tx,
    input wire logic clocks_gated,
    input wire logic [1:0] general_clock_sel
);
    // ----
    // power state checks
    // ----
    localparam int WMAX = WAKE + 3;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // link still up, so a wake rather than a drop
    sequence lpi_leave;
        $fell(lpi_active) ##0 link_up;
    endsequence
    a_ack_gated: assert property (clocks_gated && mgmt_rd |=> mgmt_ack)
        else $error("no ack while gated");
    a_lpi_needs_link: assert property ($rose(lpi_active) |-> lpi_link)
        else $error("idle without capable link");
    a_lpi_idle_mac: assert property ($rose(lpi_active) |-> !$past(mac_tx_busy, 2))
        else $error("idle entered mid frame");
    a_wake_bound: assert property (lpi_leave |-> ##[1:WMAX] tx_ready)
        else $error("wake too slow");
    a_lpi_gates: assert property (lpi_active |-> clocks_gated && !tx_ready)
        else $error("idle not gated");
    a_refresh_lpi: assert property (refresh_tx |-> lpi_active)
        else $error("refresh outside idle");
    a_pulse_sleep: assert property (link_pulse |-> clocks_gated && !link_pulse_continuous)
        else $error("single pulse outside sleep");
    a_clk_off_reset: assert property ($rose(rstn) |-> general_clock_sel == GCLK_OFF)
        else $error("output clock on after reset");
endmodule
bind lowpower_control lowpower_asserts #(.WAKE(WAKE)) u_lowpower_asserts (.*);
`default_nettype wire

//--- verification/mac_model.sv
`timescale 1ns/1ps
`default_nettype none
module mac_model (
    // bench controls
    input wire logic sys_clk,
    input wire logic want,
    input wire logic rogue,
    // block status
    input wire logic lpi_link,
    input wire logic mac_tx_busy,
    // request
    output logic mac_lpi_request
);
    // rogue lets a scenario ask for idle when it must be refused
    initial mac_lpi_request = 1'h0;
    always @(negedge sys_clk)
        mac_lpi_request <= want && (rogue || (lpi_link && !mac_tx_busy));
endmodule
`default_nettype wire

//--- verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
    import lowpower_pkg::*;
;
    logic sys_clk = 1'h0, rstn = 1'h0, mgmt_wr = 1'h0, mgmt_rd = 1'h0, line_energy = 1'h0;
    logic link_up = 1'h0, link_fast = 1'h0, partner_lpi_fast = 1'h0, mac_tx_busy = 1'h0;
    logic want = 1'h0, rogue = 1'h0, mac_lpi_request, mgmt_ack, tx_ready, lpi_link, lpi_active;
    logic link_pulse, link_pulse_continuous, refresh_tx, clocks_gated, cmu_power;
    logic status_indicator_out, status_indicator_oe_n, strap_two_level_value;
    logic [15:0] mgmt_addr = 16'h0, mgmt_wdata = 16'h0, mgmt_rdata, got;
    logic [1:0] general_clock_sel;
    logic [2:0] strap_config_high = 3'h7, strap_config_low = 3'h7, strap_two_level_pin = 3'h7;
    logic activity = 1'h0, remote_wake = 1'h0;
    int n_mismatch = 0, checks = 0, cyc = 0;
    // ----
    // harness
    // ----
    lowpower_control #(.SILENCE(40), .PULSE_PERIOD(20), .WAKE(10), .REFRESH(15), .BLINK(4))
    u_lowpower_control (.*);
    mac_model u_mac_model (.*);
    always #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_mismatch++;
            final_report();
        end
    end
    task automatic final_report();
        if (n_mismatch == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] seen);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", nm, exp, seen);
        end
    endtask
    task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d);
        @(negedge sys_clk);
        {mgmt_wr, mgmt_rd, mgmt_addr, mgmt_wdata} = {w, !w, a, d};
        @(negedge sys_clk);
        chk("mgmt_ack", 16'h1, {15'h0, mgmt_ack});
        {mgmt_wr, mgmt_rd} = 2'h0;
        @(negedge sys_clk);
        got = mgmt_rdata;
    endtask
    // bounded wait, then the signal must be high
    task automatic wt(input string nm, ref logic s, input int n);
        int i;
        i = 0;
        while (s !== 1'h1 && i < n)
        begin
            @(negedge sys_clk);
            i++;
        end
        chk(nm, 16'h1, {15'h0, s});
    endtask
    // ----
    // scenarios
    // ----
    initial
    begin
        repeat (8) @(negedge sys_clk);
        rstn = 1'h1;
        repeat (6) @(negedge sys_clk);
        chk("gclk_sel", 16'h0, {14'h0, general_clock_sel});
        chk("strap_two", 16'h1, {15'h0, strap_two_level_value});
        acc(1'h0, ADDR_CTRL_STATUS_TWO, 16'h0);
        chk("sleep_en", 16'h1, {15'h0, got[SLEEP_EN_BIT]});
        acc(1'h0, ADDR_LPI_ADV, 16'h0);
        chk("lpi_adv", 16'h1, {15'h0, got[LPI_FAST_ADV_BIT]});
        acc(1'h0, 16'h0100, 16'h0);
        chk("unmapped", 16'h0, got);
        acc(1'h1, ADDR_IND_TWO, 16'h0002);
        acc(1'h0, ADDR_IND_TWO, 16'h0);
        chk("ind_fn", 16'h2, {14'h0, got[1:0]});
        repeat (60) @(negedge sys_clk);
        acc(1'h0, ADDR_CTRL_STATUS_TWO, 16'h0);
        chk("asleep", 16'h1, {15'h0, got[SLEEP_STATE_BIT]});
        wt("link_pulse", link_pulse, 25);
        line_energy = 1'h1;
        wt("pulse_cont", link_pulse_continuous, 8);
        {link_up, link_fast, partner_lpi_fast} = 3'h7;
        repeat (4) @(negedge sys_clk);
        chk("ind_lit", 16'h0, {14'h0, status_indicator_oe_n, status_indicator_out});
        activity = 1'h1;
        repeat (2) @(negedge sys_clk);
        got[0] = status_indicator_out;
        repeat (4) @(negedge sys_clk);
        chk("ind_blink", 16'h1, {15'h0, got[0] ^ status_indicator_out});
        activity = 1'h0;
        chk("lpi_link", 16'h1, {15'h0, lpi_link});
        want = 1'h1;
        wt("lpi_active", lpi_active, 10);
        wt("refresh", refresh_tx, 20);
        acc(1'h0, ADDR_LPI_ADV, 16'h0);
        chk("lpi_adv_idle", 16'h1, {15'h0, got[LPI_FAST_ADV_BIT]});
        remote_wake = 1'h1;
        wt("remote_wake", tx_ready, 16);
        remote_wake = 1'h0;
        wt("lpi_again", lpi_active, 10);
        want = 1'h0;
        wt("tx_ready", tx_ready, 16);
        {mac_tx_busy, rogue, want} = 3'h7;
        repeat (10) @(negedge sys_clk);
        chk("busy_refused", 16'h0, {15'h0, lpi_active});
        {mac_tx_busy, partner_lpi_fast} = 2'h0;
        repeat (10) @(negedge sys_clk);
        chk("adv_refused", 16'h0, {15'h0, lpi_active});
        {rogue, want} = 2'h0;
        for (int s = 3; s > 0; s--)
        begin
            acc(1'h1, ADDR_GCLK_CTRL, 16'(s));
            chk("gclk_sel", 16'(s), {14'h0, general_clock_sel});
        end
        acc(1'h1, ADDR_BASIC_CTRL, 16'h0800);
        @(negedge sys_clk);
        chk("pd_cmu", 16'h3, {14'h0, clocks_gated, cmu_power});
        acc(1'h1, ADDR_BASIC_CTRL, 16'h0);
        wt("tx_ready", tx_ready, 10);
        // second reset with straps asking for soft power-down
        rstn = 1'h0;
        {strap_config_high, strap_two_level_pin} = {3'h3, 3'h3};
        repeat (4) @(negedge sys_clk);
        rstn = 1'h1;
        repeat (6) @(negedge sys_clk);
        chk("strap_pd", 16'h2, {14'h0, clocks_gated, tx_ready});
        chk("strap_two", 16'h0, {15'h0, strap_two_level_value});
        acc(1'h0, ADDR_BASIC_CTRL, 16'h0);
        chk("pd_bit", 16'h1, {15'h0, got[SOFT_PD_BIT]});
        acc(1'h1, ADDR_BASIC_CTRL, 16'h0);
        wt("tx_ready", tx_ready, 10);
        final_report();
    end
endmodule
`default_nettype wire
